// [src/abl_consts.svh]
// Timing counts and reset values for the adaptive boost LED control block
`ifndef ABL_CONSTS_SVH
`define ABL_CONSTS_SVH
`define ABL_CLK_MHZ 125
`define ABL_NUM_SINKS 3
`define ABL_CODE_STEPS 256
`define ABL_CODE_MAX 8'hff
`define ABL_CODE_MIN 8'h00
// 0.88 of 255 rounded to nearest code
`define ABL_CODE_INIT 8'he0
`define ABL_FILT_NS 1000
`define ABL_FILT_CYC ((`ABL_FILT_NS * `ABL_CLK_MHZ + 999) / 1000)
`define ABL_STEP_US 10
`define ABL_STEP_CYC (`ABL_STEP_US * `ABL_CLK_MHZ)
`define ABL_DOWN_PERIOD 16
`define ABL_SS_DELAY_US 256
`define ABL_SS_DELAY_CYC (`ABL_SS_DELAY_US * `ABL_CLK_MHZ)
`define ABL_SYNC_LOSS_NS 4000
`define ABL_SYNC_LOSS_CYC (`ABL_SYNC_LOSS_NS * `ABL_CLK_MHZ / 1000)
`define ABL_SS_MOD_US 1000
`define ABL_SS_MOD_CYC (`ABL_SS_MOD_US * `ABL_CLK_MHZ)
`define ABL_SS_PCT 3
`define ABL_ILIM_MS 1500
`define ABL_ILIM_CYC (`ABL_ILIM_MS * 125000)
`define ABL_CLR_MIN_NS 2000
`define ABL_CLR_MIN_CYC ((`ABL_CLR_MIN_NS * `ABL_CLK_MHZ + 999) / 1000)
`define ABL_CLR_MAX_NS 20000
`define ABL_CLR_MAX_CYC (`ABL_CLR_MAX_NS * `ABL_CLK_MHZ / 1000)
`define ABL_STARTUP_CYC 250
`define ABL_F_R1_KHZ 480
`define ABL_F_R2_KHZ 1150
`define ABL_F_R3_KHZ 1650
`endif

// [src/abl_pkg.sv]
// Types for the adaptive boost LED control block
package abl_pkg;
   typedef enum logic [1:0] {ABL_SS_OFF, ABL_SS_ON, ABL_EXT_SYNC} abl_mode_t;
   typedef enum logic [1:0] {ABL_FR1, ABL_FR2, ABL_FR3, ABL_FR4} abl_frange_t;
   typedef enum {ABL_ST_DETECT, ABL_ST_RUN} abl_state_t;
endpackage : abl_pkg

// [src/abl_control.sv]
// Adaptive boost LED converter digital control
`timescale 1ns/1ns
`include "abl_consts.svh"
module abl_control (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Host pins
   input wire logic io_supply_and_enable_pin_in,
   input wire logic pwm_in,
   input wire logic sync_in,
   // Analog comparators per sink, then shared current limit and 48 V
   input wire logic [2:0] low_headroom_in,
   input wire logic [2:0] upper_headroom_in,
   input wire logic [2:0] short_detect_in,
   input wire logic [2:0] sink_grounded_in,
   input wire logic current_limit_hit_in,
   input wire logic over_48v_in,
   // Set frequency from resistor measurement, kHz
   input wire logic [11:0] set_freq_khz_in,
   // Converter controls
   output logic [7:0] target_code_out,
   output logic [2:0] sink_on_out,
   output logic fault_n_out,
   output logic open_string_fault_out,
   output logic shorted_string_fault_out,
   output abl_pkg::abl_mode_t mode_out,
   output logic signed [2:0] ss_offset_pct_out,
   output abl_pkg::abl_frange_t freq_range_out,
   output logic high_limit_out,
   output logic switch_inhibit_out
);
   import abl_pkg::*;

   // Pin synchronisers
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [26:0] cmp_s1;
   logic [26:0] cmp_s2;
   logic en_s;
   logic pwm_s;
   logic sync_s;
   logic sync_d;
   logic ilim_s;
   logic v48_s;
   assign en_s = pin_s2[0];
   assign pwm_s = pin_s2[1];
   assign sync_s = pin_s2[2];
   assign ilim_s = pin_s2[3];
   assign v48_s = pin_s2[4];

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
         cmp_s1 <= 27'h0;
         cmp_s2 <= 27'h0;
         sync_d <= 1'b0;
      end else begin
         pin_s1 <= {1'b0, over_48v_in, current_limit_hit_in, sync_in, pwm_in,
                    io_supply_and_enable_pin_in};
         pin_s2 <= pin_s1;
         cmp_s1 <= {15'h0, sink_grounded_in, short_detect_in, upper_headroom_in,
                    low_headroom_in};
         cmp_s2 <= cmp_s1;
         sync_d <= sync_s;
      end
   end

   // Comparator filters: output changes only after input steady for 1 us
   logic [8:0] filt;
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_filt
         logic [7:0] cnt;
         always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
               cnt <= 8'h00;
               filt[gi] <= 1'b0;
            end else if (cmp_s2[gi] == filt[gi]) begin
               cnt <= 8'h00;
            end else if (cnt == 8'(`ABL_FILT_CYC - 1)) begin
               cnt <= 8'h00;
               filt[gi] <= cmp_s2[gi];
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   endgenerate
   wire [2:0] f_low = filt[2:0];
   wire [2:0] f_up = filt[5:3];
   wire [2:0] f_short = filt[8:6];
   wire [2:0] grounded = cmp_s2[11:9];

   // Start-up detection and sink exclusion
   abl_state_t state;
   logic [7:0] st_cnt;
   logic [2:0] excluded;
   logic [2:0] faulty;
   logic open_flag;
   logic short_flag;
   wire [2:0] active = ~excluded & ~faulty;
   wire running = (state == ABL_ST_RUN);

   // Headroom decisions over active sinks only
   wire any_low = |(f_low & active);
   wire all_up = (active != 3'b000) && ((f_up & active) == active);
   wire [2:0] in_window = ~f_low & ~f_up & active;
   wire [2:0] short_hit = f_short & active;
   wire at_max = (target_code_out == `ABL_CODE_MAX);
   wire at_min = (target_code_out == `ABL_CODE_MIN);
   wire open_det = running && any_low && at_max;
   logic [2:0] short_det;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_short
         assign short_det[gi] = running && short_hit[gi] &&
                                ((in_window & ~(3'b001 << gi)) != 3'b000);
      end
   endgenerate

   // Step timer with periodic down pressure
   logic [10:0] step_cnt;
   logic [3:0] down_cnt;
   wire step_tick = (step_cnt == 11'(`ABL_STEP_CYC - 1));
   wire nudge = step_tick && (down_cnt == 4'(`ABL_DOWN_PERIOD - 1));
   logic [7:0] next_code;
   always_comb begin
      next_code = target_code_out;
      if (running && step_tick) begin
         if (any_low) begin
            if (!at_max) next_code = target_code_out + 8'h01;
         end else if (all_up || nudge) begin
            if (!at_min) next_code = target_code_out - 8'h01;
         end
         // Otherwise in window: hold
      end
   end

   // Fault clear by short enable low pulse; longer low restarts
   logic [11:0] en_low_cnt;
   wire en_rise = en_s && (en_low_cnt != 12'h000);
   wire clr_pulse = en_rise && (en_low_cnt >= 12'(`ABL_CLR_MIN_CYC)) &&
                    (en_low_cnt <= 12'(`ABL_CLR_MAX_CYC));
   wire restart = en_rise && (en_low_cnt > 12'(`ABL_CLR_MAX_CYC));

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state <= ABL_ST_DETECT;
         st_cnt <= 8'h00;
         excluded <= 3'b000;
         faulty <= 3'b000;
         open_flag <= 1'b0;
         short_flag <= 1'b0;
         target_code_out <= `ABL_CODE_INIT;
         step_cnt <= 11'h000;
         down_cnt <= 4'h0;
         en_low_cnt <= 12'h000;
      end else begin
         if (!en_s) begin
            if (en_low_cnt != 12'hfff) en_low_cnt <= en_low_cnt + 12'h001;
         end else begin
            en_low_cnt <= 12'h000;
         end
         step_cnt <= step_tick ? 11'h000 : step_cnt + 11'h001;
         if (step_tick) down_cnt <= down_cnt + 4'h1;
         if (restart) begin
            state <= ABL_ST_DETECT;
            st_cnt <= 8'h00;
            excluded <= 3'b000;
            faulty <= 3'b000;
            open_flag <= 1'b0;
            short_flag <= 1'b0;
            target_code_out <= `ABL_CODE_INIT;
         end else begin
            target_code_out <= next_code;
            case (state)
               ABL_ST_DETECT: begin
                  if (en_s) begin
                     if (st_cnt == 8'(`ABL_STARTUP_CYC - 1)) begin
                        excluded <= grounded;
                        state <= ABL_ST_RUN;
                     end else begin
                        st_cnt <= st_cnt + 8'h01;
                     end
                  end
               end
               ABL_ST_RUN: begin
                  // New detections win over a clear in the same cycle
                  faulty <= faulty | (open_det ? (f_low & active) : 3'b000) | short_det;
                  open_flag <= open_det | (open_flag & ~clr_pulse);
                  short_flag <= (short_det != 3'b000) | (short_flag & ~clr_pulse);
               end
               default: state <= ABL_ST_DETECT;
            endcase
         end
      end
   end

   // Sync mode detection; loss of toggling means internal clock
   logic [9:0] sync_idle;
   logic ext_seen;
   logic [15:0] ss_wait;
   abl_mode_t next_mode;
   logic sync_clk;
   wire sync_edge = sync_s ^ sync_d;
   wire sync_lost = (sync_idle == 10'(`ABL_SYNC_LOSS_CYC));
   // A lone level change is not a clock: two edges inside the window are
   wire ext_live = !sync_lost && sync_clk;
   wire ss_due = (ss_wait == 16'(`ABL_SS_DELAY_CYC - 1));
   // Without a live clock the internal rate runs; spread only on a high pin
   always_comb begin
      next_mode = ABL_SS_OFF;
      if (ext_live) next_mode = ABL_EXT_SYNC;
      else if (sync_s && (!ext_seen || ss_due || mode_out == ABL_SS_ON)) next_mode = ABL_SS_ON;
   end
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sync_idle <= 10'(`ABL_SYNC_LOSS_CYC);
         ext_seen <= 1'b0;
         ss_wait <= 16'h0000;
         sync_clk <= 1'b0;
         mode_out <= ABL_SS_OFF;
      end else begin
         if (sync_edge) sync_idle <= 10'h000;
         else if (!sync_lost) sync_idle <= sync_idle + 10'h001;
         if (sync_lost) sync_clk <= 1'b0;
         else if (sync_edge) sync_clk <= 1'b1;
         // Remember an external clock so a later high pin waits before spreading
         if (ext_live) ext_seen <= 1'b1;
         else if (!sync_s) ext_seen <= 1'b0;
         if (!ext_live && sync_s && mode_out != ABL_SS_ON) ss_wait <= ss_wait + 16'h0001;
         else ss_wait <= 16'h0000;
         mode_out <= next_mode;
      end
   end

   // Spread spectrum: triangle -3..+3 percent at 1 kHz
   logic [17:0] ss_cnt;
   logic [3:0] ss_phase;
   wire ss_tick = (ss_cnt == 18'(`ABL_SS_MOD_CYC / 12 - 1));
   // Up three, down six, up three: the sweep is centred on zero
   wire ss_rise = (ss_phase < 4'h3) || (ss_phase > 4'h8);
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ss_cnt <= 18'h00000;
         ss_phase <= 4'h0;
         ss_offset_pct_out <= 3'sh0;
      end else begin
         ss_cnt <= ss_tick ? 18'h00000 : ss_cnt + 18'h00001;
         if (mode_out != ABL_SS_ON) begin
            // Restart at the centre so the offset never leaves three percent
            ss_phase <= 4'h0;
            ss_offset_pct_out <= 3'sh0;
         end else if (ss_tick) begin
            ss_phase <= (ss_phase == 4'hb) ? 4'h0 : ss_phase + 4'h1;
            ss_offset_pct_out <= ss_rise ?
               ss_offset_pct_out + 3'sh1 : ss_offset_pct_out - 3'sh1;
         end
      end
   end

   // Frequency range from set frequency
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) freq_range_out <= ABL_FR1;
      else if (set_freq_khz_in < 12'(`ABL_F_R1_KHZ)) freq_range_out <= ABL_FR1;
      else if (set_freq_khz_in < 12'(`ABL_F_R2_KHZ)) freq_range_out <= ABL_FR2;
      else if (set_freq_khz_in < 12'(`ABL_F_R3_KHZ)) freq_range_out <= ABL_FR3;
      else freq_range_out <= ABL_FR4;
   end

   // Current limit escalation timer
   logic [27:0] ilim_cnt;
   logic ilim_busy;
   wire ilim_done = (ilim_cnt == 28'(`ABL_ILIM_CYC - 1));
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ilim_cnt <= 28'h0;
         ilim_busy <= 1'b0;
         high_limit_out <= 1'b0;
      end else if (!ilim_busy) begin
         if (ilim_s) begin
            ilim_busy <= 1'b1;
            high_limit_out <= 1'b1;
         end
      end else if (ilim_done) begin
         ilim_cnt <= 28'h0;
         // 2.5 A phase ends into a 2 A phase; after 2 A phase re-arm on demand
         if (high_limit_out) high_limit_out <= 1'b0;
         else ilim_busy <= 1'b0;
      end else begin
         ilim_cnt <= ilim_cnt + 28'h1;
      end
   end

   // Outputs
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sink_on_out <= 3'b000;
         switch_inhibit_out <= 1'b1;
         fault_n_out <= 1'b1;
         open_string_fault_out <= 1'b0;
         shorted_string_fault_out <= 1'b0;
      end else begin
         sink_on_out <= {3{pwm_s & en_s & running}} & active;
         switch_inhibit_out <= v48_s | ~running;
         fault_n_out <= ~(open_flag | short_flag);
         open_string_fault_out <= open_flag;
         shorted_string_fault_out <= short_flag;
      end
   end
endmodule : abl_control

// [verification/abl_control_assertions.sv]
// Port-level checks for the adaptive boost LED control
`timescale 1ns/1ns
module abl_control_assertions (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Watched ports
   input wire logic io_supply_and_enable_pin_in,
   input wire logic pwm_in,
   input wire logic over_48v_in,
   input wire logic [7:0] target_code_out,
   input wire logic [2:0] sink_on_out,
   input wire logic fault_n_out,
   input wire logic open_string_fault_out,
   input wire logic shorted_string_fault_out,
   input wire abl_pkg::abl_mode_t mode_out,
   input wire logic signed [2:0] ss_offset_pct_out,
   input wire logic switch_inhibit_out
);
   import abl_pkg::*;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_ovp_hold;
      over_48v_in [*3];
   endsequence
   sequence s_dark_hold;
      (!pwm_in || !io_supply_and_enable_pin_in) [*5];
   endsequence
   a_init_target: assert property ($rose(rst_n_in) |-> target_code_out == 8'he0)
      else $error("target not at start code");
   a_step_unit: assert property ($changed(target_code_out) |->
      (target_code_out == $past(target_code_out) + 8'h01 && target_code_out != 8'h00) ||
      (target_code_out == $past(target_code_out) - 8'h01 && target_code_out != 8'hff))
      else $error("target moved by other than one saturating step");
   a_step_spacing: assert property ($changed(target_code_out) |=> $stable(target_code_out) [*8])
      else $error("target steps too close together");
   a_ovp_inhibit: assert property (s_ovp_hold |-> ##[0:3] switch_inhibit_out)
      else $error("switching not restrained on 48 V");
   a_dark_sinks: assert property (s_dark_hold |-> sink_on_out == 3'h0)
      else $error("sinks lit while dark");
   a_open_at_max: assert property ($rose(open_string_fault_out) |-> target_code_out == 8'hff)
      else $error("open fault below top code");
   a_fault_pin: assert property ($rose(open_string_fault_out || shorted_string_fault_out)
      |-> ##[0:2] !fault_n_out)
      else $error("fault pin not driven");
   a_no_spread: assert property ((mode_out != ABL_SS_ON) [*3] |-> ss_offset_pct_out == 3'sd0)
      else $error("spread offset outside spread mode");
endmodule : abl_control_assertions
bind abl_control abl_control_assertions u_abl_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .io_supply_and_enable_pin_in(io_supply_and_enable_pin_in), .pwm_in(pwm_in),
   .over_48v_in(over_48v_in), .target_code_out(target_code_out), .sink_on_out(sink_on_out),
   .fault_n_out(fault_n_out), .open_string_fault_out(open_string_fault_out),
   .shorted_string_fault_out(shorted_string_fault_out), .mode_out(mode_out),
   .ss_offset_pct_out(ss_offset_pct_out), .switch_inhibit_out(switch_inhibit_out));

// [verification/abl_host_model.sv]
// Host model driving enable, brightness PWM and sync pins
`timescale 1ns/1ns
module abl_host_model (
   // Clock
   input wire logic ref_clk_in,
   // Bench commands
   input wire logic en_cmd_in,
   input wire logic pwm_cmd_in,
   input wire logic [1:0] sync_sel_in,
   input wire logic [11:0] set_freq_khz_in,
   // Device pins
   output logic enable_out = 1'b0,
   output logic pwm_out = 1'b0,
   output logic sync_out = 1'b0
);
   int half_ns;
   always @(posedge ref_clk_in) begin
      enable_out <= en_cmd_in;
      pwm_out <= pwm_cmd_in;
   end
   // Sync at 1.25x set rate; static level when not toggling
   always begin
      half_ns = 400000 / int'(set_freq_khz_in);
      #(half_ns);
      sync_out <= (sync_sel_in == 2'h2) ? ~sync_out : sync_sel_in[0];
   end
endmodule : abl_host_model

// [verification/abl_control_tb.sv]
// Self-checking bench for the adaptive boost LED control
`timescale 1ns/1ns
module abl_control_tb;
   import abl_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, en_cmd = 1'b0, pwm_cmd = 1'b0, lim = 1'b0, ovp = 1'b0;
   logic [1:0] sync_sel = 2'h0;
   logic [2:0] low = 3'h0, up = 3'h0, shrt = 3'h0, gnd = 3'h4;
   logic [11:0] frequency_set_resistor_pin = 12'd500;
   logic en, pwm, sync, fault_n, opn, shr, hi_lim, inh;
   logic [7:0] tgt, old;
   logic [2:0] sinks;
   logic signed [2:0] ssp;
   abl_mode_t mode;
   abl_frange_t fr;
   int err_count = 0, n_tests = 0;
   time t0;
   always #4 clk = ~clk;
   abl_host_model host (.ref_clk_in(clk), .en_cmd_in(en_cmd), .pwm_cmd_in(pwm_cmd),
      .sync_sel_in(sync_sel), .set_freq_khz_in(frequency_set_resistor_pin), .enable_out(en), .pwm_out(pwm),
      .sync_out(sync));
   abl_control dut (.ref_clk_in(clk), .rst_n_in(rst_n), .io_supply_and_enable_pin_in(en),
      .pwm_in(pwm), .sync_in(sync), .low_headroom_in(low), .upper_headroom_in(up),
      .short_detect_in(shrt), .sink_grounded_in(gnd), .current_limit_hit_in(lim),
      .over_48v_in(ovp), .set_freq_khz_in(frequency_set_resistor_pin), .target_code_out(tgt), .sink_on_out(sinks),
      .fault_n_out(fault_n), .open_string_fault_out(opn), .shorted_string_fault_out(shr),
      .mode_out(mode), .ss_offset_pct_out(ssp), .freq_range_out(fr), .high_limit_out(hi_lim),
      .switch_inhibit_out(inh));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wait_step(input int n);
      old = tgt;
      for (int i = 0; i < n && tgt === old; i++) cyc(1);
   endtask : wait_step
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic t_start();
      check(tgt, 8'he0);
      check(mode, ABL_SS_OFF);
      en_cmd = 1'b1;
      pwm_cmd = 1'b1;
      cyc(400);
      check(sinks, 3'h3);
      pwm_cmd = 1'b0;
      cyc(6);
      check(sinks, 3'h0);
      pwm_cmd = 1'b1;
   endtask : t_start
   task automatic t_freq();
      logic [11:0] f [4] = '{12'd300, 12'd800, 12'd1400, 12'd2000};
      for (int i = 0; i < 4; i++) begin
         frequency_set_resistor_pin = f[i];
         cyc(4);
         check(fr, i);
      end
      frequency_set_resistor_pin = 12'd500;
   endtask : t_freq
   task automatic t_misc();
      lim = 1'b1;
      cyc(10);
      check(hi_lim, 1'b1);
      lim = 1'b0;
      ovp = 1'b1;
      cyc(6);
      check(inh, 1'b1);
      ovp = 1'b0;
      cyc(6);
      check(inh, 1'b0);
   endtask : t_misc
   // Pulse inside the clear window; longer would restart the device
   task automatic t_clear();
      en_cmd = 1'b0;
      cyc(500);
      en_cmd = 1'b1;
      cyc(50);
      check({opn, shr, fault_n}, 3'h1);
   endtask : t_clear
   task automatic t_short();
      shrt = 3'h2;
      cyc(1500);
      check({shr, fault_n, sinks}, {1'b1, 1'b0, 3'h1});
      shrt = 3'h0;
      t_clear();
   endtask : t_short
   task automatic t_open();
      low = 3'h1;
      wait_step(1600);
      check(tgt, old + 8'h01);
      for (int i = 0; i < 45000 && opn !== 1'b1; i++) cyc(1);
      check({tgt, opn, fault_n, sinks[0]}, {8'hff, 1'b1, 1'b0, 1'b0});
      low = 3'h0;
      t_clear();
   endtask : t_open
   task automatic t_down();
      up = 3'h7;
      wait_step(1600);
      check(tgt, old - 8'h01);
      up = 3'h0;
   endtask : t_down
   task automatic t_sync();
      sync_sel = 2'h1;
      cyc(700);
      check(mode, ABL_SS_ON);
      sync_sel = 2'h2;
      cyc(3000);
      check(mode, ABL_EXT_SYNC);
      sync_sel = 2'h1;
      t0 = $time;
      cyc(1000);
      check(mode, ABL_SS_OFF);
      wait_step(22000);
      check(tgt, old - 8'h01);
      while (mode !== ABL_SS_ON && $time - t0 < 300000) cyc(1);
      check(($time - t0) / 8 inside {[32000:33600]}, 1'b1);
      sync_sel = 2'h2;
      cyc(3000);
      sync_sel = 2'h0;
      cyc(700);
      check(mode, ABL_SS_OFF);
      check(ssp, 3'sh0);
   endtask : t_sync
   // Step-down runs while two sinks are still live; faults later remove them
   initial begin
      cyc(5);
      rst_n = 1'b1;
      t_start();
      t_freq();
      t_misc();
      t_down();
      t_short();
      t_open();
      t_sync();
      give_verdict();
   end
   // Run needs about 83k cycles
   initial begin
      repeat (98000) @(posedge clk);
      err_count++;
      give_verdict();
   end
endmodule : abl_control_tb
